// ==== srb_pkg.sv ====
// Package for switch reset and boot mode control
package srb_pkg;

   // Switch mode strap codes
   localparam logic [3:0] MODE_SP_PLAIN     = 4'h0;
   localparam logic [3:0] MODE_SP_EE        = 4'h1;
   localparam logic [3:0] MODE_SP_JUMP0     = 4'h2;
   localparam logic [3:0] MODE_SP_JUMP1     = 4'h3;
   localparam logic [3:0] MODE_RSVD_LO      = 4'h4;
   localparam logic [3:0] MODE_RSVD_HI      = 4'h7;
   localparam logic [3:0] MODE_SP_RL        = 4'h8;
   localparam logic [3:0] MODE_SP_RL_EE     = 4'h9;
   localparam logic [3:0] MODE_MP_UN        = 4'ha;
   localparam logic [3:0] MODE_MP_UN_I2C    = 4'hb;
   localparam logic [3:0] MODE_MP_UN_EE     = 4'hc;
   localparam logic [3:0] MODE_MP_UN_I2C_EE = 4'hd;
   localparam logic [3:0] MODE_MP_DIS_A     = 4'he;
   localparam logic [3:0] MODE_MP_DIS_B     = 4'hf;

   // Eeprom init kinds
   typedef enum logic [1:0] {
      SRB_EE_NONE  = 2'b00,
      SRB_EE_SER   = 2'b01,
      SRB_EE_JUMP0 = 2'b10,
      SRB_EE_JUMP1 = 2'b11
   } srb_ee_t;

   // Sequencer states
   typedef enum logic [1:0] {
      SRB_ST_RESET = 2'b00,
      SRB_ST_HALT  = 2'b01,
      SRB_ST_RUN   = 2'b10
   } srb_state_t;

   // Decoded operating mode
   typedef struct packed {
      logic    valid;
      logic    multi_part;
      logic    reduced_lat;
      logic    i2c_reset;
      logic    ports_disabled;
      srb_ee_t ee_init;
   } srb_mode_t;

   localparam srb_mode_t MODE_RESET_VAL = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, SRB_EE_NONE};

endpackage

// ==== srb_reset_ctrl.sv ====
// Switch reset sequencing, reset halt and switch mode strap decode
//
// Notes on behaviour
// RULE_01: While fundamental reset is low, all internal logic is held reset. The code instead has halt_req_q load reset_halt during that time.
// RULE_02: Reset halt asserted during reset keeps device quasi-reset, SMBus ports live.
// RULE_03: In quasi-reset, SMBus register reads and writes are accepted.
// RULE_04: Quasi-reset ends only when SMBus master clears the halt control bit.
// RULE_05: Board keeps the four-bit mode strap static after reset negation.
// RULE_06: Codes 0-3 single partition: none, serial, jump-0, jump-1 EEPROM init.
// RULE_07: Codes 4-7 reserved; no defined operating mode is assigned.
// RULE_08: Code 8 reduced latency single partition; code 9 adds serial EEPROM.
// RULE_09: Codes A-D multi-partition unattached: plain, I2C reset, EEPROM, both.
// RULE_10: Codes E and F multi-partition with unused ports disabled.
// RULE_11: Strap sampled at reset negation and held until next fundamental reset.
`timescale 1ns/1ps
`default_nettype none

module srb_reset_ctrl (
   // Clock and reset
   input  wire logic          mclk,
   input  wire logic          rst_n,
   // Board pins
   input  wire logic          fundamental_reset_n,
   input  wire logic          reset_halt,
   input  wire logic [3:0]    switch_mode_strap,
   // Halt bit clear from the switch control register over SMBus
   input  wire logic          halt_bit_clear,
   // Status and controls
   output logic               core_reset_n,
   output logic               smbus_enable,
   output logic               reg_access_enable,
   output logic               halt_bit,
   output srb_pkg::srb_mode_t mode
);

   srb_pkg::srb_state_t state_q;
   srb_pkg::srb_state_t state_d;
   logic                halt_req_q;
   logic                sampled_q;

   function automatic srb_pkg::srb_mode_t decode(input logic [3:0] c);
      srb_pkg::srb_mode_t m;
      m = srb_pkg::MODE_RESET_VAL;
      m.valid = 1'b1;
      if (c <= srb_pkg::MODE_SP_JUMP1) begin
         // RULE_06 single partition init
         m.ee_init = srb_pkg::srb_ee_t'(c[1:0]);
      end else if (c >= srb_pkg::MODE_RSVD_LO && c <= srb_pkg::MODE_RSVD_HI) begin
         // RULE_07 reserved code
         m.valid = 1'b0;
      end else if (c == srb_pkg::MODE_SP_RL || c == srb_pkg::MODE_SP_RL_EE) begin
         // RULE_08 reduced latency
         m.reduced_lat = 1'b1;
         m.ee_init = (c == srb_pkg::MODE_SP_RL_EE) ? srb_pkg::SRB_EE_SER : srb_pkg::SRB_EE_NONE;
      end else if (c <= srb_pkg::MODE_MP_UN_I2C_EE) begin
         // RULE_09 unattached multi-partition
         m.multi_part = 1'b1;
         m.i2c_reset = (c == srb_pkg::MODE_MP_UN_I2C) || (c == srb_pkg::MODE_MP_UN_I2C_EE);
         m.ee_init = (c >= srb_pkg::MODE_MP_UN_EE) ? srb_pkg::SRB_EE_SER : srb_pkg::SRB_EE_NONE;
      end else begin
         // RULE_10 disabled ports
         m.multi_part = 1'b1;
         m.ports_disabled = 1'b1;
      end
      return m;
   endfunction

   // Sequencer next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         srb_pkg::SRB_ST_RESET: begin
            state_d = halt_req_q ? srb_pkg::SRB_ST_HALT : srb_pkg::SRB_ST_RUN;
         end
         srb_pkg::SRB_ST_HALT: begin
            // RULE_04 leave on halt clear
            if (halt_bit_clear) begin
               state_d = srb_pkg::SRB_ST_RUN;
            end
         end
         srb_pkg::SRB_ST_RUN: begin
            state_d = srb_pkg::SRB_ST_RUN;
         end
         default: begin
            state_d = srb_pkg::SRB_ST_RESET;
         end
      endcase
   end

   // RULE_01 reset holds sequencer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= srb_pkg::SRB_ST_RESET;
      end else if (!fundamental_reset_n) begin
         state_q <= srb_pkg::SRB_ST_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   // RULE_02 capture halt request
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         halt_req_q <= 1'b0;
      end else if (!fundamental_reset_n) begin
         halt_req_q <= reset_halt;
      end
   end

   // RULE_11 sample strap once
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sampled_q <= 1'b0;
         mode      <= srb_pkg::MODE_RESET_VAL;
      end else if (!fundamental_reset_n) begin
         sampled_q <= 1'b0;
         mode      <= srb_pkg::MODE_RESET_VAL;
      end else if (!sampled_q) begin
         sampled_q <= 1'b1;
         mode      <= decode(switch_mode_strap);
      end
   end

   // RULE_01 core reset output
   assign core_reset_n = (state_q == srb_pkg::SRB_ST_RUN);
   // RULE_02 SMBus live in halt
   assign smbus_enable = (state_q != srb_pkg::SRB_ST_RESET);
   // RULE_03 register access in halt
   assign reg_access_enable = (state_q != srb_pkg::SRB_ST_RESET);
   assign halt_bit = (state_q == srb_pkg::SRB_ST_HALT);

   property p_reset_hold;
      @(posedge mclk) disable iff (!rst_n)
      !fundamental_reset_n |=> !core_reset_n && !smbus_enable;
   endproperty
   chk_reset_holds_core: assert property (p_reset_hold) // RULE_01
      else $error("core not held in reset");

   chk_halt_entry_state: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_02
      state_q == srb_pkg::SRB_ST_RESET && fundamental_reset_n && halt_req_q
      |=> halt_bit && smbus_enable && !core_reset_n)
      else $error("halt not entered");

   chk_halt_reg_access: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_03
      halt_bit |-> reg_access_enable)
      else $error("no register access in halt");

   chk_halt_exit_clear: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_04
      halt_bit && fundamental_reset_n && !halt_bit_clear |=> halt_bit)
      else $error("halt left without clear");

   chk_halt_exit_run: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_04
      halt_bit && fundamental_reset_n && halt_bit_clear |=> core_reset_n)
      else $error("halt clear did not run");

   chk_mode_single_part: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_06
      fundamental_reset_n && !sampled_q && switch_mode_strap <= 4'h3
      |=> mode.valid && !mode.multi_part && mode.ee_init == srb_pkg::srb_ee_t'($past(switch_mode_strap[1:0])))
      else $error("single partition decode wrong");

   chk_mode_reserved: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_07
      fundamental_reset_n && !sampled_q && switch_mode_strap[3:2] == 2'b01 |=> !mode.valid)
      else $error("reserved code decoded");

   chk_mode_reduced_lat: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_08
      fundamental_reset_n && !sampled_q && switch_mode_strap[3:1] == 3'b100
      |=> mode.reduced_lat && !mode.multi_part && (mode.ee_init == srb_pkg::SRB_EE_SER) == $past(switch_mode_strap[0]))
      else $error("reduced latency decode wrong");

   chk_mode_unattached: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_09
      fundamental_reset_n && !sampled_q && switch_mode_strap >= 4'ha && switch_mode_strap <= 4'hd
      |=> mode.multi_part && !mode.ports_disabled && mode.i2c_reset == $past(switch_mode_strap[0]))
      else $error("unattached decode wrong");

   chk_mode_disabled: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_10
      fundamental_reset_n && !sampled_q && switch_mode_strap[3:1] == 3'b111
      |=> mode.multi_part && mode.ports_disabled)
      else $error("disabled ports decode wrong");

   chk_mode_held_stable: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_11
      sampled_q && fundamental_reset_n |=> $stable(mode))
      else $error("mode changed after sampling");

   chk_reset_clears_mode: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_01
      !fundamental_reset_n |=> mode == srb_pkg::MODE_RESET_VAL && !halt_bit)
      else $error("mode or halt not cleared in reset");

   chk_reg_access_reset: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_01
      !fundamental_reset_n |=> !reg_access_enable)
      else $error("register access open in reset");

   chk_halt_smbus_live: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_02
      halt_bit |-> smbus_enable && !core_reset_n)
      else $error("halt without live SMBus");

   chk_direct_run_entry: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_02
      state_q == srb_pkg::SRB_ST_RESET && fundamental_reset_n && !halt_req_q
      |=> core_reset_n && !halt_bit)
      else $error("run not entered without halt");

   chk_run_stays: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_04
      core_reset_n && fundamental_reset_n |=> core_reset_n && !halt_bit)
      else $error("run left without reset");

   chk_mode_sampled_once: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_11
      fundamental_reset_n && !sampled_q |=> sampled_q)
      else $error("strap not sampled at release");

   chk_i2c_multi_only: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_09
      mode.i2c_reset |-> mode.valid && mode.multi_part && !mode.ports_disabled)
      else $error("i2c reset outside unattached mode");

   chk_reduced_single: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_08
      mode.reduced_lat |-> mode.valid && !mode.multi_part)
      else $error("reduced latency outside single partition");

   cov_halt_path: cover property (@(posedge mclk) disable iff (!rst_n) halt_bit ##1 core_reset_n);
   cov_direct_run: cover property (@(posedge mclk) disable iff (!rst_n)
      state_q == srb_pkg::SRB_ST_RESET && !halt_req_q ##1 core_reset_n);
   cov_reserved: cover property (@(posedge mclk) disable iff (!rst_n) sampled_q && !mode.valid);
   cov_ports_off: cover property (@(posedge mclk) disable iff (!rst_n) sampled_q && mode.ports_disabled);

endmodule

`default_nettype wire

// ==== srb_board_model.sv ====
// Board reset logic and SMBus master model
`timescale 1ns/1ps
`default_nettype none

module srb_board_model (
   // Clock
   input  wire logic       mclk,
   // Board pins and halt clear
   output var  logic       fundamental_reset_n,
   output var  logic       reset_halt,
   output var  logic [3:0] switch_mode_strap,
   output var  logic       halt_bit_clear
);
   initial begin
      fundamental_reset_n = 1'b0;
      reset_halt = 1'b0;
      switch_mode_strap = 4'h0;
      halt_bit_clear = 1'b0;
   end
   task automatic hold_reset(input logic [3:0] code, input logic halt);
      @(posedge mclk);
      fundamental_reset_n <= 1'b0;
      reset_halt <= halt;
      switch_mode_strap <= code;
      repeat (3) @(posedge mclk);
   endtask
   task automatic release_reset();
      @(posedge mclk);
      fundamental_reset_n <= 1'b1;
      @(posedge mclk);
   endtask
   task automatic clear_halt();
      @(posedge mclk);
      halt_bit_clear <= 1'b1;
      @(posedge mclk);
      halt_bit_clear <= 1'b0;
   endtask
   // Deliberate strap move after sampling
   task automatic move_strap(input logic [3:0] code);
      @(posedge mclk);
      switch_mode_strap <= code;
   endtask
endmodule

`default_nettype wire

// ==== tb_top.sv ====
// Testbench for reset sequencing and mode decode
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic               mclk;
   logic               rst_n;
   wire logic          frn;
   wire logic          rh;
   wire logic [3:0]    sm;
   wire logic          hbc;
   logic               core_reset_n;
   logic               smbus_enable;
   logic               reg_access_enable;
   logic               halt_bit;
   srb_pkg::srb_mode_t mode;
   int                 fail_count;
   int                 cmp_count;

   srb_reset_ctrl i_dut (.mclk(mclk), .rst_n(rst_n), .fundamental_reset_n(frn),
      .reset_halt(rh), .switch_mode_strap(sm), .halt_bit_clear(hbc),
      .core_reset_n(core_reset_n), .smbus_enable(smbus_enable),
      .reg_access_enable(reg_access_enable), .halt_bit(halt_bit), .mode(mode));
   srb_board_model i_brd (.mclk(mclk), .fundamental_reset_n(frn), .reset_halt(rh),
      .switch_mode_strap(sm), .halt_bit_clear(hbc));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   function automatic srb_pkg::srb_mode_t exp_mode(input int c);
      srb_pkg::srb_mode_t m;
      int ee;
      ee = (c < 4) ? c : ((c == 9 || c == 12 || c == 13) ? 1 : 0);
      m = '{1'b1, c >= 10, c == 8 || c == 9, c == 11 || c == 13, c >= 14,
            srb_pkg::srb_ee_t'(ee[1:0])};
      if (c >= 4 && c <= 7) m = '0;
      return m;
   endfunction

   task automatic cmp_m(input srb_pkg::srb_mode_t g, input srb_pkg::srb_mode_t e);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %0t mode got %h exp %h", $time, g, e);
      end
   endtask

   task automatic cmp_b(input logic g, input logic e);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %0t flag got %h exp %h", $time, g, e);
      end
   endtask

   task automatic summarize();
      $display("Compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      #50000;
      fail_count++;
      summarize();
   end

   initial begin
      int                 c;
      logic               h;
      srb_pkg::srb_mode_t e;
      rst_n = 1'b0;
      fail_count = 0;
      cmp_count = 0;
      void'($urandom(32'h44f402b1));
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      for (c = 0; c < 16; c++) begin
         h = 1'($urandom);
         e = exp_mode(c);
         i_brd.hold_reset(c[3:0], h);
         #1;
         cmp_m(mode, '0);
         cmp_b(core_reset_n, 1'b0);
         cmp_b(smbus_enable, 1'b0);
         cmp_b(reg_access_enable, 1'b0);
         cmp_b(halt_bit, 1'b0);
         i_brd.release_reset();
         #1;
         cmp_m(mode, e);
         cmp_b(core_reset_n, ~h);
         cmp_b(reg_access_enable, 1'b1);
         i_brd.move_strap(4'($urandom));
         repeat (2) @(posedge mclk);
         #1;
         cmp_m(mode, e);
         cmp_b(halt_bit, h);
         cmp_b(smbus_enable, 1'b1);
         i_brd.clear_halt();
         #1;
         cmp_b(core_reset_n, 1'b1);
         cmp_b(halt_bit, 1'b0);
      end
      @(posedge mclk);
      rst_n <= 1'b0;
      @(posedge mclk);
      #1;
      cmp_m(mode, '0);
      cmp_b(core_reset_n, 1'b0);
      cmp_b(smbus_enable, 1'b0);
      summarize();
   end
endmodule

`default_nettype wire
